// [src/cfs_supervisor.sv]
// fault latch, discharge, restart sequencing and power-good for a buck
`timescale 1ns/1ps
module cfs_supervisor
    import cfs_pkg::*;
#(
    parameter int UV_RUN = CFS_UV_RUN_CYCLES,
    parameter int OV_RUN = CFS_OV_RUN_CYCLES
)
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire cfs_comp_t   comp_in,
    output logic             converter_on,
    output logic             low_side_discharge,
    output logic             en_pullup_on,
    output logic             en_sink_on,
    output logic             ss_discharge,
    output logic             output_in_regulation_o,
    output logic             output_in_regulation_oe,
    output logic             irq,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    localparam int UVW = $clog2(UV_RUN + 1);
    localparam int OVW = $clog2(OV_RUN + 1);
    localparam logic [UVW-1:0] UV_LAST = UVW'(UV_RUN - 1);
    localparam logic [OVW-1:0] OV_LAST = OVW'(OV_RUN - 1);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    cfs_comp_t             cmp;
    cfs_state_t            state;
    cfs_state_t            next_state;
    logic                  clr;
    logic                  fault_latch;
    logic                  armed;
    logic                  disch;
    logic                  ot_pending;
    logic [UVW-1:0]        uv_cnt;
    logic [OVW-1:0]        ov_cnt;
    logic                  uv_fault;
    logic                  ov_fault;
    logic                  short_fault;
    logic                  ot_fault;
    logic                  fault_set;
    logic                  may_start;
    logic                  output_in_regulation;
    logic [3:0]            cause;
    logic [CFS_EV_W-1:0]   events;
    logic [CFS_EV_W-1:0]   irq_stat;
    logic [CFS_EV_W-1:0]   irq_mask;
    logic [2:0]            state_code;
    logic [31:0]           status_word;
    logic                  setup;
    logic                  access;
    logic                  mapped;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [CFS_COMP_W-1:0] cmp_bits;
    cfs_pin_sync #(
        .W       (CFS_COMP_W)
    ) u_sync (
        .core_clk(core_clk),
        .rst     (rst),
        .ce      (ce),
        .pin_in  (comp_in),
        .pin_out (cmp_bits)
    );
    assign cmp = cfs_comp_t'(cmp_bits);

    // ------------------------------------------------------------------
    // fault detection
    // ------------------------------------------------------------------
    // lockout clears all fault and sequencing state, not the irq registers; enable toggles clear on the next entry to soft start
    assign clr = cmp.bias_lockout;
    assign armed = (state == ST_RUN);

    // 16th unbroken cycle, only once armed
    assign uv_fault = armed && cmp.uv_comp
                      && (uv_cnt == UV_LAST);
    // second unbroken cycle, any phase
    assign ov_fault = cmp.ov_comp && (ov_cnt == OV_LAST);
    // no filtering, acts in the same cycle
    assign short_fault = cmp.sw_above_short
                         && cmp.low_side_full;
    assign ot_fault = cmp.die_hot;

    assign fault_set = (uv_fault || ov_fault || short_fault || ot_fault)
                       && (state != ST_OFF);

    assign may_start = cmp.en_above_start && !ot_pending;

    always_ff @(posedge core_clk)
    begin
        if (rst || clr)
            uv_cnt <= '0;
        else if (ce)
        begin
            if (!cmp.uv_comp || !armed)
                uv_cnt <= '0;
            else if (uv_cnt != UV_LAST)
                uv_cnt <= uv_cnt + UVW'(1);
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || clr)
            ov_cnt <= '0;
        else if (ce)
        begin
            if (!cmp.ov_comp)
                ov_cnt <= '0;
            else if (ov_cnt != OV_LAST)
                ov_cnt <= ov_cnt + OVW'(1);
        end
    end

    // over-temperature blocks restart until the die cools
    always_ff @(posedge core_clk)
    begin
        if (rst || clr)
            ot_pending <= 1'b0;
        else if (ce)
        begin
            if (cmp.die_hot)
                ot_pending <= 1'b1;
            else if (cmp.die_cool)
                ot_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // restart sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_OFF:
                if (may_start)
                    next_state = ST_SOFT;
            ST_SOFT:
                if (fault_set)
                    next_state = ST_DRAIN;
                else if (!cmp.en_above_start)
                    next_state = ST_OFF;
                else if (cmp.ss_at_arm)
                    next_state = ST_RUN;
            ST_RUN:
                if (fault_set)
                    next_state = ST_DRAIN;
                else if (!cmp.en_above_start)
                    next_state = ST_OFF;
            ST_DRAIN:
                // a pin held high never leaves this state
                if (cmp.en_below_reset)
                    next_state = ST_RECHG;
            ST_RECHG:
                if (may_start)
                    next_state = ST_SOFT;
            default:
                next_state = ST_OFF;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || clr)
            state <= ST_OFF;
        else if (ce)
            state <= next_state;
    end

    // ------------------------------------------------------------------
    // fault latch and cause
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst || clr)
            fault_latch <= 1'b0;
        else if (ce)
        begin
            if (fault_set)
                fault_latch <= 1'b1;
            else if (state == ST_OFF || next_state == ST_SOFT)
                fault_latch <= 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst || clr)
            cause <= 4'h0;
        else if (ce)
        begin
            if (fault_set && !fault_latch)
                cause <= {ot_fault, short_fault, ov_fault, uv_fault};
            else if (next_state == ST_SOFT && state != ST_SOFT)
                cause <= 4'h0;
        end
    end

    // ------------------------------------------------------------------
    // output discharge with hysteresis
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (rst || clr)
            disch <= 1'b0;
        else if (ce)
        begin
            if (fault_set && !fault_latch)
                disch <= !cmp.fb_below_low;
            else if (!fault_latch || next_state == ST_SOFT)
                disch <= 1'b0;
            else if (cmp.fb_below_low)
                disch <= 1'b0;
            else if (cmp.fb_above_high)
                disch <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // pin drives
    // ------------------------------------------------------------------
    assign converter_on = (state == ST_SOFT || state == ST_RUN)
                          && !fault_latch;
    assign low_side_discharge = disch;
    assign en_sink_on   = (state == ST_DRAIN);
    assign en_pullup_on = (state != ST_DRAIN);
    assign ss_discharge = !(state == ST_SOFT || state == ST_RUN);

    // open drain: drive low unless in window and armed
    assign output_in_regulation = cmp.fb_in_window && armed && !fault_latch;
    assign output_in_regulation_o  = 1'b0;
    assign output_in_regulation_oe = !output_in_regulation;

    // ------------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------------
    always_comb
    begin
        events                 = '0;
        events[CFS_EV_UV]      = uv_fault && !fault_latch;
        events[CFS_EV_OV]      = ov_fault && !fault_latch;
        events[CFS_EV_SHORT]   = short_fault && !fault_latch;
        events[CFS_EV_OT]      = ot_fault && !fault_latch;
        events[CFS_EV_RESTART] = (next_state == ST_SOFT) && (state != ST_SOFT);
        events[CFS_EV_ARMED]   = (next_state == ST_RUN) && (state == ST_SOFT);
    end

    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == CFS_OFF_STATUS)
                    || (paddr == CFS_OFF_IRQ_STATUS)
                    || (paddr == CFS_OFF_IRQ_MASK);

    // read of the irq status clears; a new event in that cycle survives
    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq_stat <= CFS_RST_IRQ_STAT;
        else if (ce)
        begin
            if (access && !pwrite && paddr == CFS_OFF_IRQ_STATUS)
                irq_stat <= events;
            else
                irq_stat <= irq_stat | events;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
            irq_mask <= CFS_RST_IRQ_MASK;
        else if (ce && access && pwrite && paddr == CFS_OFF_IRQ_MASK)
            irq_mask <= pwdata[CFS_EV_W-1:0];
    end

    assign irq = |(irq_stat & irq_mask);

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    assign state_code = 3'(state);

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[CFS_ST_LATCH]  = fault_latch;
        status_word[CFS_ST_ARMED]  = armed;
        status_word[CFS_ST_OUTPUT_IN_REGULATION]  = output_in_regulation;
        status_word[CFS_ST_DISCH]  = disch;
        status_word[CFS_ST_PULLUP] = en_pullup_on;
        status_word[CFS_ST_OTPEND] = ot_pending;
        status_word[CFS_ST_STATE_LO +: 3] = state_code;
        status_word[CFS_ST_CAUSE_LO +: 4] = cause;
    end

    // read data captured in the setup cycle, stable through access
    always_ff @(posedge core_clk)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (ce && setup)
        begin
            case (paddr)
                CFS_OFF_STATUS:     prdata <= status_word;
                CFS_OFF_IRQ_STATUS: prdata <= {26'h0, irq_stat};
                CFS_OFF_IRQ_MASK:   prdata <= {26'h0, irq_mask};
                default:            prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign pready  = access;
    assign pslverr = access && !mapped;

endmodule // cfs_supervisor

// [src/cfs_pkg.sv]
// shared constants and types for the converter fault supervisor
package cfs_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] CFS_OFF_STATUS     = 8'h00;
    localparam logic [7:0] CFS_OFF_IRQ_STATUS = 8'h04;
    localparam logic [7:0] CFS_OFF_IRQ_MASK   = 8'h08;

    // ------------------------------------------------------------------
    // status word field positions
    // ------------------------------------------------------------------
    localparam int CFS_ST_LATCH    = 0;
    localparam int CFS_ST_ARMED    = 1;
    localparam int CFS_ST_OUTPUT_IN_REGULATION    = 2;
    localparam int CFS_ST_DISCH    = 3;
    localparam int CFS_ST_PULLUP   = 4;
    localparam int CFS_ST_OTPEND   = 5;
    localparam int CFS_ST_STATE_LO = 8;
    localparam int CFS_ST_CAUSE_LO = 16;

    // ------------------------------------------------------------------
    // event bits, shared by irq status and irq mask
    // ------------------------------------------------------------------
    localparam int CFS_EV_UV      = 0;
    localparam int CFS_EV_OV      = 1;
    localparam int CFS_EV_SHORT   = 2;
    localparam int CFS_EV_OT      = 3;
    localparam int CFS_EV_RESTART = 4;
    localparam int CFS_EV_ARMED   = 5;
    localparam int CFS_EV_W       = 6;

    // ------------------------------------------------------------------
    // reset values and run lengths in oscillator cycles
    // ------------------------------------------------------------------
    localparam logic [CFS_EV_W-1:0] CFS_RST_IRQ_MASK = 6'h00;
    localparam logic [CFS_EV_W-1:0] CFS_RST_IRQ_STAT = 6'h00;
    localparam int CFS_UV_RUN_CYCLES = 16;
    localparam int CFS_OV_RUN_CYCLES = 2;

    // ------------------------------------------------------------------
    // analog comparator results from outside the clock domain
    // ------------------------------------------------------------------
    typedef struct packed {
        logic bias_lockout;    // bias supply below lockout
        logic uv_comp;         // feedback below under-voltage threshold
        logic ov_comp;         // feedback above over-voltage threshold
        logic fb_below_low;    // feedback below 0.25 V
        logic fb_above_high;   // feedback above 0.5 V
        logic sw_above_short;  // switch node above about 0.7 V
        logic low_side_full;   // low-side switch fully enhanced
        logic die_hot;         // die at about 150 C
        logic die_cool;        // die below 125 C
        logic en_above_start;  // enable pin above 1.35 V
        logic en_below_reset;  // enable pin at or below 1.1 V
        logic ss_at_arm;       // soft-start ramp reached 1.0 V
        logic fb_in_window;    // feedback inside regulation window
    } cfs_comp_t;

    localparam int CFS_COMP_W = $bits(cfs_comp_t);

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,
        ST_SOFT,
        ST_RUN,
        ST_DRAIN,
        ST_RECHG
    } cfs_state_t;

endpackage

// [src/cfs_pin_sync.sv]
// three-stage synchroniser with second/third stage agreement
`timescale 1ns/1ps
module cfs_pin_sync
#(
    parameter int W = 1
)
(
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out
);

    // ------------------------------------------------------------------
    // per-bit stages
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            always_ff @(posedge core_clk)
            begin
                if (rst)
                begin
                    s1         <= 1'b0;
                    s2         <= 1'b0;
                    s3         <= 1'b0;
                    pin_out[i] <= 1'b0;
                end
                else if (ce)
                begin
                    s1 <= pin_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    // accept only once two later stages agree
                    if (s2 == s3)
                        pin_out[i] <= s3;
                end
            end
        end
    endgenerate

endmodule // cfs_pin_sync

// [testbench/cfs_en_model.sv]
// enable-pin network model: left open, held high or grounded
`timescale 1ns/1ps
module cfs_en_model
(
    input  wire logic core_clk,
    input  wire logic pullup_on,
    input  wire logic sink_on,
    input  wire logic hold_high,
    input  wire logic to_ground,
    output logic      above_start,
    output logic      below_reset
);
    // ------------------------------------------------------------------
    // pin level, one step of charge per cycle
    // ------------------------------------------------------------------
    int level = 0;

    always_ff @(posedge core_clk)
    begin
        if (to_ground)
            level <= 0;
        else if (hold_high)
            level <= 20;
        else if (sink_on && level > 0)
            level <= level - 1;
        else if (pullup_on && !sink_on && level < 20)
            level <= level + 1;
    end

    assign above_start = level >= 8;
    assign below_reset = level <= 5;
endmodule // cfs_en_model

// [testbench/cfs_supervisor_chk.sv]
// port-level assertions for the converter fault supervisor
`timescale 1ns/1ps
module cfs_supervisor_chk
    import cfs_pkg::*;
#(
    parameter int UV_RUN = CFS_UV_RUN_CYCLES,
    parameter int OV_RUN = CFS_OV_RUN_CYCLES
)
(
    input wire logic      core_clk,
    input wire logic      rst,
    input wire cfs_comp_t comp_in,
    input wire logic      converter_on,
    input wire logic      low_side_discharge,
    input wire logic      en_pullup_on,
    input wire logic      en_sink_on,
    input wire logic      ss_discharge,
    input wire logic      output_in_regulation_o,
    input wire logic      output_in_regulation_oe
);
    // ------------------------------------------------------------------
    // run counters, allowing for synchroniser delay
    // ------------------------------------------------------------------
    localparam int UV_LIMIT = UV_RUN + 12;
    localparam int OV_LIMIT = OV_RUN + 6;
    logic [7:0] uv_run;
    logic [7:0] ov_run;
    wire        uv_live = comp_in.uv_comp && comp_in.ss_at_arm && converter_on;
    wire        ov_live = comp_in.ov_comp && converter_on;

    always_ff @(posedge core_clk)
    begin
        uv_run <= (rst || !uv_live) ? 8'h00 : uv_run + 8'h01;
        ov_run <= (rst || !ov_live) ? 8'h00 : ov_run + 8'h01;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_uv_run_trip: assert property (uv_run < UV_LIMIT)
        else $error("under-voltage run left converter on");
    a_ov_run_trip: assert property (ov_run < OV_LIMIT)
        else $error("over-voltage run left converter on");
    a_short_trip: assert property (
        (comp_in.sw_above_short && comp_in.low_side_full && converter_on)[*3]
        |-> ##[0:4] !converter_on) else $error("short left converter on");
    a_sink_no_pull: assert property (
        en_sink_on |-> !en_pullup_on && !converter_on)
        else $error("sink on together with pull-up or converter");
    a_disch_latched: assert property (
        low_side_discharge |-> !converter_on)
        else $error("discharge while converter runs");
    a_drain_stops: assert property (
        comp_in.fb_below_low[*6] |-> !low_side_discharge)
        else $error("discharge kept on below low level");
    a_pg_window: assert property (
        (!comp_in.fb_in_window)[*6] |-> output_in_regulation_oe)
        else $error("power-good released outside window");
    a_pg_unarmed: assert property (
        (!comp_in.ss_at_arm)[*6] |-> output_in_regulation_oe)
        else $error("power-good released before arming");
    a_pg_drain_low: assert property (output_in_regulation_o == 1'b0)
        else $error("power-good driven high");
    a_lockout_clear: assert property (
        comp_in.bias_lockout[*6]
        |-> ss_discharge && !converter_on && !low_side_discharge)
        else $error("lockout did not clear sequencing");
    a_restart_pull: assert property (
        $rose(converter_on) |-> $past(en_pullup_on) && !$past(en_sink_on))
        else $error("start without pull-up restored");

    c_trip: cover property ($fell(converter_on) && en_sink_on);
    c_recharge: cover property ($fell(en_sink_on));
    c_pg_good: cover property ($fell(output_in_regulation_oe));
    c_lockout: cover property (comp_in.bias_lockout && ss_discharge);
endmodule // cfs_supervisor_chk

// [testbench/testbench.sv]
// self-checking bench for the converter fault supervisor
`timescale 1ns/1ps
module testbench import cfs_pkg::*;;
    logic        core_clk = 1'b0;
    logic        rst, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        converter_on, low_side_discharge, en_pullup_on, en_sink_on;
    logic        ss_discharge, output_in_regulation_o, output_in_regulation_oe;
    logic        irq, hold, gnd, en_hi, en_lo;
    cfs_comp_t   comp, comp_bus;
    int          mismatches = 0;
    int          checks = 0;

    always #5 core_clk = ~core_clk;
    always_comb
    begin
        comp_bus = comp;
        comp_bus.en_above_start = en_hi;
        comp_bus.en_below_reset = en_lo;
    end

    cfs_supervisor dut_u (.core_clk(core_clk), .rst(rst), .ce(1'b1),
        .comp_in(comp_bus), .converter_on(converter_on),
        .low_side_discharge(low_side_discharge), .en_pullup_on(en_pullup_on),
        .en_sink_on(en_sink_on), .ss_discharge(ss_discharge),
        .output_in_regulation_o(output_in_regulation_o),
        .output_in_regulation_oe(output_in_regulation_oe), .irq(irq),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    cfs_en_model en_u (.core_clk(core_clk), .pullup_on(en_pullup_on),
        .sink_on(en_sink_on), .hold_high(hold), .to_ground(gnd),
        .above_start(en_hi), .below_reset(en_lo));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge core_clk);
            n++;
        end
        chk(pready, 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wait_conv(input logic lvl);
        int n;
        n = 0;
        while (converter_on !== lvl && n < 400)
        begin
            @(posedge core_clk);
            n++;
        end
        chk(converter_on, lvl);
    endtask

    // ------------------------------------------------------------------
    // one fault of kind k: 0 uv, 1 ov, 2 short, 3 over-temperature
    // ------------------------------------------------------------------
    task automatic trip(input int k);
        apb(1'b0, CFS_OFF_IRQ_STATUS, 32'h0);
        comp.uv_comp <= (k == 0);
        comp.ov_comp <= (k == 1);
        comp.sw_above_short <= (k == 2);
        comp.low_side_full <= (k == 2);
        comp.die_hot <= (k == 3);
        comp.die_cool <= (k != 3);
        wait_conv(1'b0);
        chk(irq, 1'b1);
        apb(1'b0, CFS_OFF_IRQ_STATUS, 32'h0);
        chk(rd, 32'h1 << k);
        comp.uv_comp <= 1'b0;
        comp.ov_comp <= 1'b0;
        comp.sw_above_short <= 1'b0;
        comp.low_side_full <= 1'b0;
        comp.die_hot <= 1'b0;
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        end_sim();
    end

    initial
    begin
        comp = '0;
        comp.die_cool = 1'b1;
        comp.fb_below_low = 1'b1;
        comp.fb_in_window = 1'b1;
        {rst, psel, penable, pwrite, paddr, pwdata, hold, gnd} = '0;
        rst = 1'b1;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        wait_conv(1'b1);
        chk(output_in_regulation_oe, 1'b1);
        chk(irq, 1'b0);
        apb(1'b0, CFS_OFF_IRQ_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, CFS_OFF_IRQ_MASK, 32'h3f);
        chk(irq, 1'b1);
        apb(1'b0, CFS_OFF_IRQ_STATUS, 32'h0);
        chk(rd, 32'h10);
        chk(irq, 1'b0);
        comp.ss_at_arm <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk(output_in_regulation_oe, 1'b0);
        comp.fb_in_window <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(output_in_regulation_oe, 1'b1);
        comp.fb_in_window <= 1'b1;
        repeat (2)
        begin
            comp.uv_comp <= 1'b1;
            repeat (14) @(posedge core_clk);
            comp.uv_comp <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
        chk(converter_on, 1'b1);
        hold <= 1'b1;
        comp.fb_above_high <= 1'b1;
        comp.fb_below_low <= 1'b0;
        trip(0);
        repeat (8) @(posedge core_clk);
        chk(low_side_discharge, 1'b1);
        chk({en_sink_on, en_pullup_on}, 2'b10);
        comp.fb_above_high <= 1'b0;
        comp.fb_below_low <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk(low_side_discharge, 1'b0);
        comp.fb_below_low <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(low_side_discharge, 1'b0);
        comp.fb_above_high <= 1'b1;
        repeat (8) @(posedge core_clk);
        chk(low_side_discharge, 1'b1);
        comp.fb_above_high <= 1'b0;
        comp.fb_below_low <= 1'b1;
        comp.ss_at_arm <= 1'b0;
        repeat (100) @(posedge core_clk);
        chk(converter_on, 1'b0);
        hold <= 1'b0;
        wait_conv(1'b1);
        comp.uv_comp <= 1'b1;
        repeat (40) @(posedge core_clk);
        chk(converter_on, 1'b1);
        comp.uv_comp <= 1'b0;
        for (int k = 1; k < 4; k++)
        begin
            trip(k);
            repeat (100) @(posedge core_clk);
            chk(converter_on, k != 3);
            comp.die_cool <= 1'b1;
            wait_conv(1'b1);
        end
        gnd <= 1'b1;
        wait_conv(1'b0);
        gnd <= 1'b0;
        wait_conv(1'b1);
        comp.bias_lockout <= 1'b1;
        wait_conv(1'b0);
        chk(ss_discharge, 1'b1);
        comp.bias_lockout <= 1'b0;
        wait_conv(1'b1);
        end_sim();
    end
endmodule // testbench

bind cfs_supervisor cfs_supervisor_chk #(.UV_RUN(UV_RUN), .OV_RUN(OV_RUN))
    chk_u (.core_clk(core_clk), .rst(rst), .comp_in(comp_in),
    .converter_on(converter_on), .low_side_discharge(low_side_discharge),
    .en_pullup_on(en_pullup_on), .en_sink_on(en_sink_on),
    .ss_discharge(ss_discharge),
    .output_in_regulation_o(output_in_regulation_o),
    .output_in_regulation_oe(output_in_regulation_oe));
